//--- emb_pkg.sv
// emb_pkg: constants for the external memory bus pin block.
// assumes a single 40 MHz clock domain.
package emb_pkg;
  localparam int unsigned CLK_HZ           = 40000000;
  // register byte addresses on the apb slave
  localparam logic [11:0] SYSCFG_ADDR      = 12'h000;
  localparam logic [11:0] DIR0_ADDR        = 12'h004;
  localparam logic [11:0] DIR1_ADDR        = 12'h008;
  localparam logic [11:0] DIR4_ADDR        = 12'h00C;
  localparam logic [11:0] OUT0_ADDR        = 12'h010;
  localparam logic [11:0] OUT1_ADDR        = 12'h014;
  localparam logic [11:0] OUT4_ADDR        = 12'h018;
  localparam logic [11:0] STATUS_ADDR      = 12'h01C;
  // system_config_reg fields
  localparam int unsigned CFG_BUS_EN_BIT   = 0;
  localparam int unsigned CFG_WIDE_BIT     = 1;
  localparam int unsigned CFG_MUX_BIT      = 2;
  localparam int unsigned CFG_STROBE_BIT   = 3;
  localparam int unsigned CFG_RDY_EN_BIT   = 4;
  localparam int unsigned CFG_RDY_POL_BIT  = 5;
  localparam int unsigned CFG_BIDIR_BIT    = 6;
  localparam int unsigned CFG_SEG_EN_BIT   = 7;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  // internal reset sequence length in cycles
  localparam int unsigned RST_SEQ_CYC      = 16;
  typedef enum logic [2:0] {
    EMB_IDLE  = 3'b000,
    EMB_ADDR  = 3'b001,
    EMB_STRB  = 3'b010,
    EMB_WAIT  = 3'b011,
    EMB_DONE  = 3'b100
  } emb_state_e;
endpackage

//--- emb_core.sv
// emb_core: external memory bus pin sequencer with apb config registers.
// assumes pins arrive asynchronous and are synchronised here; one clock.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module emb_core #(
  parameter int unsigned SEG_W = 8
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // internal bus request
  input  wire logic        i_req,
  input  wire logic        i_req_write,
  input  wire logic        i_req_low_byte,
  input  wire logic [23:0] i_req_addr,
  input  wire logic [15:0] i_req_wdata,
  output logic             o_req_done,
  output logic      [15:0] o_req_rdata,
  output logic             o_boot_external,
  // external bus pins
  output logic             o_read_strobe_n,
  output logic             o_store_strobe_n,
  output logic             o_addr_latch,
  input  wire logic        i_ready_pin,
  input  wire logic        i_boot_source_select_n,
  input  wire logic [15:0] i_address_data_port,
  output logic      [15:0] o_address_data_port,
  output logic      [15:0] o_address_data_port_oe_n,
  output logic      [15:0] o_address_port,
  output logic      [15:0] o_address_port_oe_n,
  output logic [SEG_W-1:0] o_segment_address_port,
  output logic [SEG_W-1:0] o_segment_address_port_oe_n,
  input  wire logic        i_reset_input_n,
  output logic             o_reset_input_n,
  output logic             o_reset_input_oe_n,
  output logic             o_reset_seq
);
  if (SEG_W < 1 || SEG_W > 8) begin : g_chk
    $error("SEG_W must be 1..8");
  end

  // ready, boot and reset pin synchronisers run through reset so the boot level is settled at release; ad1_r and ad2_r clear in reset
  logic [2:0] s1_r, s2_r, s1_nxt, s2_nxt;
  logic [15:0] ad1_r, ad2_r;
  always_comb begin
    s1_nxt = {i_ready_pin, i_boot_source_select_n, i_reset_input_n};
    s2_nxt = s1_r;
  end
  always_ff @(posedge i_clk) begin
    s1_r <= s1_nxt;
    s2_r <= s2_nxt;
    if (i_srst) begin
      ad1_r <= 16'h0000;
      ad2_r <= 16'h0000;
    end else begin
      ad1_r <= i_address_data_port;
      ad2_r <= ad1_r;
    end
  end
  logic rdy_s, boot_s, rst_s;
  assign rdy_s  = s2_r[2];
  assign boot_s = s2_r[1];
  assign rst_s  = s2_r[0];

  // registers
  logic [7:0]  cfg_r, cfg_nxt;
  logic [15:0] dir0_r, dir1_r, out0_r, out1_r, dir0_nxt, dir1_nxt, out0_nxt, out1_nxt;
  logic [7:0]  dir4_r, out4_r, dir4_nxt, out4_nxt;
  logic        demux_seen_r, demux_seen_nxt;
  logic        boot_r, boot_nxt, boot_cap_r, boot_cap_nxt;
  logic        wr_en, acc;
  logic [4:0]  rcnt_r, rcnt_nxt;
  logic [1:0]  hold_r, hold_nxt;
  logic        rseq;

  assign acc   = i_psel && i_penable;
  assign wr_en = acc && i_pwrite;
  assign o_pready = 1'b1;

  always_comb begin
    cfg_nxt  = cfg_r;
    dir0_nxt = dir0_r;
    dir1_nxt = dir1_r;
    dir4_nxt = dir4_r;
    out0_nxt = out0_r;
    out1_nxt = out1_r;
    out4_nxt = out4_r;
    if (wr_en) begin
      case (i_paddr)
        emb_pkg::SYSCFG_ADDR: cfg_nxt  = i_pwdata[7:0];
        emb_pkg::DIR0_ADDR:   dir0_nxt = i_pwdata[15:0];
        emb_pkg::DIR1_ADDR:   dir1_nxt = i_pwdata[15:0];
        emb_pkg::DIR4_ADDR:   dir4_nxt = i_pwdata[7:0];
        emb_pkg::OUT0_ADDR:   out0_nxt = i_pwdata[15:0];
        emb_pkg::OUT1_ADDR:   out1_nxt = i_pwdata[15:0];
        emb_pkg::OUT4_ADDR:   out4_nxt = i_pwdata[7:0];
        default:              cfg_nxt  = cfg_r;
      endcase
    end
    // once demux used, second port keeps address role
    demux_seen_nxt = demux_seen_r
      | (cfg_r[emb_pkg::CFG_BUS_EN_BIT] & ~cfg_r[emb_pkg::CFG_MUX_BIT]);
    if (!cfg_r[emb_pkg::CFG_BUS_EN_BIT]) demux_seen_nxt = 1'b0;
    // boot level caught one cycle after release, then held
    boot_cap_nxt = 1'b1;
    boot_nxt     = boot_cap_r ? boot_r : ~boot_s;
  end

  always_comb begin
    o_pslverr = 1'b0;
    o_prdata  = 32'h0000_0000;
    if (acc && !i_pwrite) begin
      case (i_paddr)
        emb_pkg::SYSCFG_ADDR: o_prdata = {24'h000000, cfg_r};
        emb_pkg::DIR0_ADDR:   o_prdata = {16'h0000, dir0_r};
        emb_pkg::DIR1_ADDR:   o_prdata = {16'h0000, dir1_r};
        emb_pkg::DIR4_ADDR:   o_prdata = {24'h000000, dir4_r};
        emb_pkg::OUT0_ADDR:   o_prdata = {16'h0000, out0_r};
        emb_pkg::OUT1_ADDR:   o_prdata = {16'h0000, out1_r};
        emb_pkg::OUT4_ADDR:   o_prdata = {24'h000000, out4_r};
        emb_pkg::STATUS_ADDR: o_prdata = {27'h0000000, rseq, demux_seen_r, rst_s,
                                          rdy_s, boot_r};
        default:              o_pslverr = 1'b1;
      endcase
    end else if (acc) begin
      case (i_paddr)
        emb_pkg::SYSCFG_ADDR, emb_pkg::DIR0_ADDR, emb_pkg::DIR1_ADDR,
        emb_pkg::DIR4_ADDR, emb_pkg::OUT0_ADDR, emb_pkg::OUT1_ADDR,
        emb_pkg::OUT4_ADDR:   o_pslverr = 1'b0;
        default:              o_pslverr = 1'b1;
      endcase
    end
  end

  // reset sequence; hold_r masks our own pull still in the sync after it ends
  always_comb begin
    rcnt_nxt = rcnt_r;
    hold_nxt = (rcnt_r == 5'h01) ? 2'h3 : (hold_r != 2'h0) ? hold_r - 2'h1 : 2'h0;
    if (!rst_s && !rseq && hold_r == 2'h0) rcnt_nxt = 5'(emb_pkg::RST_SEQ_CYC);
    else if (rcnt_r != 5'h00) rcnt_nxt = rcnt_r - 5'h01;
  end
  assign rseq = (rcnt_r != 5'h00);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_r        <= emb_pkg::CFG_RESET;
      dir0_r       <= emb_pkg::WORD_RESET;
      dir1_r       <= emb_pkg::WORD_RESET;
      dir4_r       <= 8'h00;
      out0_r       <= emb_pkg::WORD_RESET;
      out1_r       <= emb_pkg::WORD_RESET;
      out4_r       <= 8'h00;
      demux_seen_r <= 1'b0;
      boot_r       <= 1'b0;
      boot_cap_r   <= 1'b0;
      rcnt_r       <= 5'h00;
      hold_r       <= 2'h0;
    end else begin
      cfg_r        <= rseq ? emb_pkg::CFG_RESET : cfg_nxt;
      dir0_r       <= dir0_nxt;
      dir1_r       <= dir1_nxt;
      dir4_r       <= dir4_nxt;
      out0_r       <= out0_nxt;
      out1_r       <= out1_nxt;
      out4_r       <= out4_nxt;
      demux_seen_r <= demux_seen_nxt;
      boot_r       <= boot_nxt;
      boot_cap_r   <= boot_cap_nxt;
      rcnt_r       <= rcnt_nxt;
      hold_r       <= hold_nxt;
    end
  end
  assign o_boot_external = boot_r;
  assign o_reset_seq     = rseq;
  // bidir bit kept through sequence via latched copy
  logic bidir_r;
  always_ff @(posedge i_clk) begin
    if (i_srst) bidir_r <= 1'b0;
    else if (!rseq) bidir_r <= cfg_r[emb_pkg::CFG_BIDIR_BIT];
  end
  assign o_reset_input_n    = 1'b0;
  assign o_reset_input_oe_n = ~(bidir_r & rseq);

  // bus sequencer
  emb_pkg::emb_state_e st_r, st_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic        wr_r, wr_nxt, lb_r, lb_nxt, done_r, done_nxt;
  logic        bus_en, mux, wide, rdy_ok;
  assign bus_en = cfg_r[emb_pkg::CFG_BUS_EN_BIT];
  assign mux    = cfg_r[emb_pkg::CFG_MUX_BIT];
  assign wide   = cfg_r[emb_pkg::CFG_WIDE_BIT];
  assign rdy_ok = !cfg_r[emb_pkg::CFG_RDY_EN_BIT]
                || (rdy_s == cfg_r[emb_pkg::CFG_RDY_POL_BIT]);

  always_comb begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    wd_nxt   = wd_r;
    rd_nxt   = rd_r;
    wr_nxt   = wr_r;
    lb_nxt   = lb_r;
    done_nxt = 1'b0;
    case (st_r)
      emb_pkg::EMB_IDLE: if (i_req && bus_en && !rseq) begin
        addr_nxt = i_req_addr;
        wd_nxt   = i_req_wdata;
        wr_nxt   = i_req_write;
        lb_nxt   = i_req_low_byte;
        st_nxt   = emb_pkg::EMB_ADDR;
      end
      emb_pkg::EMB_ADDR: st_nxt = emb_pkg::EMB_STRB;
      emb_pkg::EMB_STRB: st_nxt = emb_pkg::EMB_WAIT;
      emb_pkg::EMB_WAIT: if (rdy_ok) st_nxt = emb_pkg::EMB_DONE;
      emb_pkg::EMB_DONE: begin
        rd_nxt   = wide ? ad2_r : {8'h00, ad2_r[7:0]};
        done_nxt = 1'b1;
        st_nxt   = emb_pkg::EMB_IDLE;
      end
      default:           st_nxt = emb_pkg::EMB_IDLE;
    endcase
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r   <= emb_pkg::EMB_IDLE;
      addr_r <= 24'h000000;
      wd_r   <= 16'h0000;
      rd_r   <= 16'h0000;
      wr_r   <= 1'b0;
      lb_r   <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
      wd_r   <= wd_nxt;
      rd_r   <= rd_nxt;
      wr_r   <= wr_nxt;
      lb_r   <= lb_nxt;
      done_r <= done_nxt;
    end
  end
  assign o_req_done  = done_r;
  assign o_req_rdata = rd_r;

  logic strobing, strobe_store;
  assign strobing = (st_r == emb_pkg::EMB_STRB) || (st_r == emb_pkg::EMB_WAIT);
  assign strobe_store = !cfg_r[emb_pkg::CFG_STROBE_BIT] || !wide || lb_r;
  assign o_read_strobe_n  = ~(strobing && !wr_r);
  assign o_store_strobe_n = ~(strobing && wr_r && strobe_store);
  assign o_addr_latch     = (st_r == emb_pkg::EMB_ADDR) && mux;

  // port muxing
  always_comb begin
    if (bus_en) begin
      if (mux && strobing && !wr_r) begin
        o_address_data_port      = addr_r[15:0];
        o_address_data_port_oe_n = 16'hFFFF;
      end else if (mux && !strobing) begin
        o_address_data_port      = addr_r[15:0];
        o_address_data_port_oe_n = 16'h0000;
      end else begin
        o_address_data_port      = wd_r;
        o_address_data_port_oe_n = (strobing && wr_r) ? 16'h0000 : 16'hFFFF;
      end
    end else begin
      o_address_data_port      = out0_r;
      o_address_data_port_oe_n = ~dir0_r;
    end
    if (bus_en && (!mux || demux_seen_r)) begin
      o_address_port      = addr_r[15:0];
      o_address_port_oe_n = 16'h0000;
    end else begin
      o_address_port      = out1_r;
      o_address_port_oe_n = ~dir1_r;
    end
  end

  for (genvar g = 0; g < SEG_W; g++) begin : g_seg
    logic seg_bus;
    assign seg_bus = bus_en && cfg_r[emb_pkg::CFG_SEG_EN_BIT];
    assign o_segment_address_port[g]      = seg_bus ? addr_r[16+g] : out4_r[g];
    assign o_segment_address_port_oe_n[g] = seg_bus ? 1'b0 : ~dir4_r[g];
  end

  strobe_excl_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !(!o_read_strobe_n && !o_store_strobe_n)) else $error("both strobes low");
  idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r == emb_pkg::EMB_IDLE) |-> (o_read_strobe_n && o_store_strobe_n))
    else $error("strobe outside access");
  read_strobe_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r == emb_pkg::EMB_ADDR && !wr_r) |=> !o_read_strobe_n)
    else $error("read strobe missing");
  sequence s_wait; (st_r == emb_pkg::EMB_WAIT) && !rdy_ok; endsequence
  wait_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    s_wait |=> (st_r == emb_pkg::EMB_WAIT)) else $error("wait state skipped");
  word_store_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_r == emb_pkg::EMB_STRB && wr_r && !cfg_r[emb_pkg::CFG_STROBE_BIT])
    |-> !o_store_strobe_n) else $error("word mode strobe missing");
  low_byte_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (strobing && wr_r && wide && !lb_r && cfg_r[emb_pkg::CFG_STROBE_BIT])
    |-> o_store_strobe_n) else $error("high byte strobed");
  latch_mux_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_addr_latch |-> (mux && $past(st_r) == emb_pkg::EMB_IDLE))
    else $error("address latch misplaced");
  rst_pull_a: assert property (@(posedge i_clk) disable iff (i_srst)
    ($fell(rst_s) && !rseq && bidir_r) |=> !o_reset_input_oe_n [*8])
    else $error("reset not pulled low");
  addr_bus_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (bus_en && !mux) |-> (o_address_port_oe_n == 16'h0000))
    else $error("address port not driven");
endmodule // emb_core
`default_nettype wire

//--- emb_ext_mem.sv
// emb_ext_mem: external memory on the parallel bus pins.
// assumes the device clock and active-low strobes; ready stall is per access.
`timescale 1ns/1ps
`default_nettype none
module emb_ext_mem (
  // device side
  input  wire logic        i_clk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_ale,
  input  wire logic        i_demux,
  input  wire logic [15:0] i_ad_out,
  input  wire logic [15:0] i_ad_oe_n,
  input  wire logic [15:0] i_a_out,
  // ready timing
  input  wire logic        i_rdy_pol,
  input  wire logic [3:0]  i_wait,
  // line levels
  output logic      [15:0] o_ad_level,
  output logic             o_ready
);
  logic [15:0] mem_r [16];
  logic [15:0] last_r = 16'hA5A5;
  logic [3:0]  adr_r = 4'h0;
  logic [3:0]  cnt_r = 4'h0;
  logic [3:0]  idx;
  assign idx = i_demux ? i_a_out[3:0] : adr_r;
  always @(posedge i_clk) begin
    if (i_ale) adr_r <= i_ad_out[3:0];
    if (i_rd_n && i_wr_n) cnt_r <= 4'h0;
    else if (cnt_r != 4'hF) cnt_r <= cnt_r + 4'h1;
    if (!i_wr_n) mem_r[idx] <= i_ad_out;
    last_r <= o_ad_level;
  end
  // stall: inactive level for i_wait cycles of each strobe
  assign o_ready = (cnt_r >= i_wait) ? i_rdy_pol : ~i_rdy_pol;
  // released lines flip rather than hold, so stale data cannot pass
  always_comb begin
    for (int b = 0; b < 16; b++)
      o_ad_level[b] = !i_ad_oe_n[b] ? i_ad_out[b] : !i_rd_n ? mem_r[idx][b] : ~last_r[b];
  end
endmodule // emb_ext_mem
`default_nettype wire

//--- test_external_memory_bus_pins.sv
// test_external_memory_bus_pins: scenario bench for emb_core.
// assumes emb_pkg and the emb_ext_mem partner; reset pin pulled up here.
`timescale 1ns/1ps
`default_nettype none
module test_external_memory_bus_pins;
  localparam logic [7:0] BUS   = 8'h01 << emb_pkg::CFG_BUS_EN_BIT;
  localparam logic [7:0] WIDE  = 8'h01 << emb_pkg::CFG_WIDE_BIT;
  localparam logic [7:0] MUX   = 8'h01 << emb_pkg::CFG_MUX_BIT;
  localparam logic [7:0] LOWB  = 8'h01 << emb_pkg::CFG_STROBE_BIT;
  localparam logic [7:0] RDYE  = 8'h01 << emb_pkg::CFG_RDY_EN_BIT;
  localparam logic [7:0] RDYP  = 8'h01 << emb_pkg::CFG_RDY_POL_BIT;
  localparam logic [7:0] BIDIR = 8'h01 << emb_pkg::CFG_BIDIR_BIT;
  localparam logic [7:0] SEGE  = 8'h01 << emb_pkg::CFG_SEG_EN_BIT;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic        i_req = 1'b0, i_req_write = 1'b0, i_req_low_byte = 1'b0, rdy_pol = 1'b1;
  logic        i_boot_source_select_n = 1'b1, rst_drv_n = 1'b1, demux = 1'b0;
  logic        o_pready, o_pslverr, o_req_done, o_boot_external, o_read_strobe_n;
  logic        o_store_strobe_n, o_addr_latch, i_ready_pin, i_reset_input_n;
  logic        o_reset_input_n, o_reset_input_oe_n, o_reset_seq;
  logic [3:0]  wait_c = 4'h0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000, o_prdata;
  logic [23:0] i_req_addr = 24'h000000;
  logic [15:0] i_req_wdata = 16'h0000, o_req_rdata, i_address_data_port, o_address_data_port;
  logic [15:0] o_address_data_port_oe_n, o_address_port, o_address_port_oe_n, ap_seen, ap_oe;
  logic [7:0]  o_segment_address_port, o_segment_address_port_oe_n, seg_seen, seg_oe;
  int          fails, compares, n_rd, n_wr, n_ale;

  emb_core uut (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_req, .i_req_write, .i_req_low_byte, .i_req_addr,
    .i_req_wdata, .o_req_done, .o_req_rdata, .o_boot_external, .o_read_strobe_n,
    .o_store_strobe_n, .o_addr_latch, .i_ready_pin, .i_boot_source_select_n,
    .i_address_data_port, .o_address_data_port, .o_address_data_port_oe_n, .o_address_port,
    .o_address_port_oe_n, .o_segment_address_port, .o_segment_address_port_oe_n,
    .i_reset_input_n, .o_reset_input_n, .o_reset_input_oe_n, .o_reset_seq);
  emb_ext_mem mem (.i_clk, .i_rd_n(o_read_strobe_n), .i_wr_n(o_store_strobe_n),
    .i_ale(o_addr_latch), .i_demux(demux), .i_ad_out(o_address_data_port),
    .i_ad_oe_n(o_address_data_port_oe_n), .i_a_out(o_address_port), .i_rdy_pol(rdy_pol),
    .i_wait(wait_c), .o_ad_level(i_address_data_port), .o_ready(i_ready_pin));
  // pull-up unless someone drives the reset line low
  assign i_reset_input_n = (o_reset_input_oe_n === 1'b0) ? o_reset_input_n : rst_drv_n;

  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    n_rd += (o_read_strobe_n === 1'b0);
    n_wr += (o_store_strobe_n === 1'b0);
    n_ale += (o_addr_latch === 1'b1);
    if (o_read_strobe_n === 1'b0 || o_store_strobe_n === 1'b0) begin
      ap_seen = o_address_port;
      ap_oe = o_address_port_oe_n;
      seg_seen = o_segment_address_port;
      seg_oe = o_segment_address_port_oe_n;
    end
  end

  task automatic summarize;
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic cfg(input logic [7:0] v);
    logic [31:0] r;
    logic        e;
    apb(1'b1, emb_pkg::SYSCFG_ADDR, {24'h000000, v}, r, e);
    demux <= !v[emb_pkg::CFG_MUX_BIT];
  endtask
  task automatic access(input logic w, input logic lb, input logic [23:0] a,
                        input logic [15:0] wd, output logic [15:0] rd, output int c);
    n_rd = 0;
    n_wr = 0;
    n_ale = 0;
    i_req <= 1'b1;
    i_req_write <= w;
    i_req_low_byte <= lb;
    i_req_addr <= a;
    i_req_wdata <= wd;
    @(posedge i_clk);
    i_req <= 1'b0;
    c = 1;
    while (o_req_done !== 1'b1 && c < 60) begin
      @(posedge i_clk);
      c++;
    end
    rd = o_req_rdata;
    check("done_seen", 1, c < 60);
  endtask
  task automatic do_reset(input logic b);
    i_boot_source_select_n <= b;
    i_srst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    check("idle_strobes", 2'b11, {o_read_strobe_n, o_store_strobe_n});
    check("address_data_port_float", 16'hFFFF, o_address_data_port_oe_n);
    apb(1'b1, emb_pkg::DIR0_ADDR, 32'h000000FF, r, e);
    apb(1'b1, emb_pkg::OUT0_ADDR, 32'h00001234, r, e);
    @(posedge i_clk);
    check("address_data_port_dir", 16'hFF00, o_address_data_port_oe_n);
    check("address_data_port_out", 8'h34, o_address_data_port[7:0]);
    apb(1'b0, emb_pkg::DIR0_ADDR, 32'h00000000, r, e);
    check("dir0_read", 32'h000000FF, r);
    apb(1'b0, 12'h020, 32'h00000000, r, e);
    check("unmapped_err", 1, e);
    apb(1'b0, emb_pkg::STATUS_ADDR, 32'h00000000, r, e);
    check("status_read", 32'h00000006, r);
  endtask
  task automatic t_strobes;
    logic [15:0] d;
    int          c;
    for (int m = 0; m < 8; m++) begin
      cfg(BUS | MUX | (m[0] ? WIDE : 8'h00) | (m[1] ? LOWB : 8'h00));
      access(1'b1, m[2], 24'h000003, 16'h5A5A, d, c);
      check("store_active", !(m[0] && m[1] && !m[2]), n_wr > 0);
      check("read_idle", 0, n_rd);
      check("latch_pulses", 1, n_ale);
    end
  endtask
  task automatic t_ready;
    logic [15:0] d;
    int          c0;
    int          c;
    cfg(BUS | MUX | WIDE);
    access(1'b1, 1'b0, 24'h000005, 16'hC35A, d, c);
    access(1'b0, 1'b0, 24'h000005, 16'h0000, d, c0);
    check("mux_read", 16'hC35A, d);
    check("read_active", 1, n_rd > 0);
    check("store_idle", 0, n_wr);
    wait_c <= 4'h6;
    access(1'b0, 1'b0, 24'h000005, 16'h0000, d, c);
    check("ready_off_cycles", c0, c);
    for (int p = 0; p < 2; p++) begin
      rdy_pol <= p[0];
      cfg(BUS | MUX | WIDE | RDYE | (p[0] ? RDYP : 8'h00));
      access(1'b0, 1'b0, 24'h000005, 16'h0000, d, c);
      check("ready_waits", 1, c >= c0 + 6 && c <= c0 + 9);
      check("ready_read", 16'hC35A, d);
    end
    wait_c <= 4'h0;
  endtask
  task automatic t_demux;
    logic [15:0] d;
    int          c;
    cfg(BUS | WIDE | SEGE);
    access(1'b1, 1'b0, 24'h5A0009, 16'h0F1E, d, c);
    access(1'b0, 1'b0, 24'h5A0009, 16'h0000, d, c);
    check("demux_read", 16'h0F1E, d);
    check("addr_port", 16'h0009, ap_seen);
    check("addr_port_oe", 16'h0000, ap_oe);
    check("no_latch", 0, n_ale);
    check("seg_port", 8'h5A, seg_seen);
    check("seg_oe", 8'h00, seg_oe);
    cfg(BUS | WIDE | MUX);
    access(1'b0, 1'b0, 24'h000009, 16'h0000, d, c);
    check("mux_after_demux", 16'h0F1E, d);
    check("addr_port_kept", 16'h0009, ap_seen);
  endtask
  task automatic t_rstpin;
    int nseq;
    int noe;
    for (int b = 0; b < 2; b++) begin
      cfg(b == 1 ? BIDIR : 8'h00);
      nseq = 0;
      noe = 0;
      rst_drv_n <= 1'b0;
      for (int k = 0; k < 64; k++) begin
        @(negedge i_clk);
        nseq += (o_reset_seq === 1'b1);
        noe += (o_reset_input_oe_n === 1'b0);
        @(posedge i_clk);
        if (k == 3) rst_drv_n <= 1'b1;
      end
      check("reset_seq_len", emb_pkg::RST_SEQ_CYC, nseq);
      check("reset_pull_len", (b == 1) ? nseq : 0, noe);
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    summarize;
  end
  initial begin
    do_reset(1'b1);
    check("boot_internal", 0, o_boot_external);
    t_regs;
    t_strobes;
    t_ready;
    t_demux;
    t_rstpin;
    do_reset(1'b0);
    check("boot_external", 1, o_boot_external);
    summarize;
  end
endmodule // test_external_memory_bus_pins
`default_nettype wire
